// >>> shared/fsw_pkg.sv
// Notes on behaviour
// - overrunning register read repeats same value
// - power-up copies non-volatile into volatile status
// - status read returns volatile copy only
// - bit 0 shows busy, default zero
// - bit 1 shows write enable latch
// - bits 2 to 5 select protected region
// - bit 6 enables quad data function
// - bit 7 locks the status register
// - latch set by enable, cleared by disable, completion, nv aux write or reset
// - busy device ignores all but listed instructions
// - completion always clears busy bit
// - write enable instruction sets the latch
// - volatile write needs 50h then 01h
// - latch cleared by disable and on completion
// - program, erase, nv writes need latch set
// - C0h and 17h run without latch
// - program/erase into protected region is inhibited
// - chip erase needs all protect bits zero
// - lock bit plus low pin blocks writes
// - lock bit with high pin allows writes
// - quad bit turns shared pins into data
package fsw_pkg;

  // -------------------------------------------------
  // status register layout
  // -------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 5;
  localparam int ST_QE = 6;
  localparam int ST_LOCK = 7;
  localparam logic [5:0] NV_RESET = 6'h00;
  localparam logic [3:0] BP_NONE = 4'h0;
  localparam logic [3:0] BP_ALL_FROM = 4'hB;
  localparam logic [10:0] BLOCK_COUNT = 11'h400;
  localparam int ADDR_BLK_LO = 16;
  localparam int ADDR_BLK_HI = 25;

  // -------------------------------------------------
  // instruction codes
  // -------------------------------------------------
  localparam logic [7:0] OP_WRITE_STATUS_INSTR = 8'h01;
  localparam logic [7:0] OP_READ_STATUS_INSTR = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE_INSTR = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE_INSTR = 8'h04;
  localparam logic [7:0] OP_VWREN = 8'h50;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_PP4 = 8'h12;
  localparam logic [7:0] OP_PPQ_A = 8'h32;
  localparam logic [7:0] OP_PPQ_B = 8'h38;
  localparam logic [7:0] OP_PPQ4_A = 8'h34;
  localparam logic [7:0] OP_PPQ4_B = 8'h3E;
  localparam logic [7:0] OP_SE_A = 8'hD7;
  localparam logic [7:0] OP_SE_B = 8'h20;
  localparam logic [7:0] OP_SE4 = 8'h21;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE32_4 = 8'h5C;
  localparam logic [7:0] OP_BE64 = 8'hD8;
  localparam logic [7:0] OP_BE64_4 = 8'hDC;
  localparam logic [7:0] OP_CE_A = 8'hC7;
  localparam logic [7:0] OP_CE_B = 8'h60;
  localparam logic [7:0] OP_WRFR = 8'h42;
  localparam logic [7:0] OP_SRPNV = 8'h65;
  localparam logic [7:0] OP_VOLATILE_READ_PARAM_WRITE = 8'h63;
  localparam logic [7:0] OP_BRV = 8'hC5;
  localparam logic [7:0] OP_ALT_RP = 8'hC0;
  localparam logic [7:0] OP_ALT_BR = 8'h17;
  localparam logic [7:0] OP_RDFR = 8'h48;
  localparam logic [7:0] OP_RDERP = 8'h81;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_SUSP_A = 8'h75;
  localparam logic [7:0] OP_SUSP_B = 8'hB0;

  // -------------------------------------------------
  // timing
  // -------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int NV_WR_TIME_NS = 50000;
  localparam int NV_WR_CYCLES = (NV_WR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 12;

  // -------------------------------------------------
  // types
  // -------------------------------------------------
  typedef enum logic [1:0] {
    FR_OPC = 2'b00,
    FR_ADDR = 2'b01,
    FR_DATA = 2'b11,
    FR_SKIP = 2'b10
  } fsw_frame_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [31:0] addr;
    logic [7:0] data;
  } fsw_op_t;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
  } fsw_spi_in_t;

endpackage

// >>> src/fsw_spi_shift.sv
`timescale 1ns/1ps
`default_nettype none
module fsw_spi_shift (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // raw pins
  input wire fsw_pkg::fsw_spi_in_t pins,
  // byte side
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic so_bit,
  output logic frame_end
);
  import fsw_pkg::*;

  fsw_spi_in_t meta_r;
  fsw_spi_in_t sync_r;
  fsw_spi_in_t last_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] rx_sh_r;
  logic [7:0] tx_sh_r;
  logic rise;
  logic fall;

  assign rise = sync_r.sck & ~last_r.sck & ~sync_r.cs_n;
  assign fall = ~sync_r.sck & last_r.sck & ~sync_r.cs_n;

  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      meta_r <= '{sck: 1'b0, cs_n: 1'b1, si: 1'b0};
      sync_r <= '{sck: 1'b0, cs_n: 1'b1, si: 1'b0};
      last_r <= '{sck: 1'b0, cs_n: 1'b1, si: 1'b0};
    end
    else if (clk_en)
    begin
      meta_r <= pins;
      sync_r <= meta_r;
      last_r <= sync_r;
    end

  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      bit_cnt_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
      frame_end <= 1'b0;
    end
    else if (clk_en)
    begin
      rx_valid <= 1'b0;
      frame_end <= sync_r.cs_n & ~last_r.cs_n;
      if (sync_r.cs_n)
        bit_cnt_r <= 3'h0;
      else if (rise)
      begin
        rx_sh_r <= {rx_sh_r[6:0], sync_r.si};
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (bit_cnt_r == 3'h7)
        begin
          rx_byte <= {rx_sh_r[6:0], sync_r.si};
          rx_valid <= 1'b1;
        end
      end
    end

  // a fresh byte is taken at every byte boundary, so a long read repeats
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      tx_sh_r <= 8'h00;
      so_bit <= 1'b0;
    end
    else if (clk_en && fall)
    begin
      if (bit_cnt_r == 3'h0)
      begin
        so_bit <= tx_byte[7];
        tx_sh_r <= {tx_byte[6:0], 1'b0};
      end
      else
      begin
        so_bit <= tx_sh_r[7];
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
      end
    end

endmodule
`default_nettype wire

// >>> src/fsw_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module fsw_ctrl (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // serial link pins
  input wire fsw_pkg::fsw_spi_in_t spi_in,
  output logic so_out,
  output logic so_oe,
  // shared pins: write protect / data_line_2, hold-reset / data_line_3
  input wire logic wp_n_dl2_in,
  output logic wp_n_dl2_out,
  output logic wp_n_dl2_oe,
  input wire logic hold_n_dl3_in,
  output logic hold_n_dl3_out,
  output logic hold_n_dl3_oe,
  output logic pins_are_data,
  // array engine
  output logic op_start,
  output fsw_pkg::fsw_op_t op_req,
  input wire logic op_done,
  // other register writes and control requests
  output logic aux_write,
  output fsw_pkg::fsw_op_t aux_req,
  output logic suspend_req,
  output logic soft_reset_req,
  output logic hw_reset_req,
  // status view
  output logic [7:0] status_out
);
  import fsw_pkg::*;

  // -------------------------------------------------
  // declarations
  // -------------------------------------------------
  logic [7:0] rx_byte;
  logic rx_valid;
  logic frame_end;
  logic so_bit;
  logic [7:0] status;
  fsw_frame_t frame_r;
  logic [7:0] opcode_r;
  logic [31:0] addr_r;
  logic [2:0] addr_left_r;
  logic [7:0] data_r;
  logic data_seen_r;
  logic read_mode_r;
  logic [5:0] vol_hi_r;
  logic [5:0] nv_hi_r;
  logic pwr_up_done_r;
  logic wel_r;
  logic busy_r;
  logic busy_tmr_r;
  logic [TMR_W-1:0] tmr_r;
  logic vol_arm_r;
  logic rst_arm_r;
  logic wp_meta_r;
  logic wp_sync_r;
  logic hold_meta_r;
  logic hold_sync_r;
  logic exec;
  logic done_evt;
  logic wp_low;
  logic locked;
  logic write_status_instr_ok;
  logic write_status_instr_vol;
  logic write_status_instr_nv;
  logic arr_ok;
  logic is_ce;
  logic aux_ok;
  logic aux_nv;

  // -------------------------------------------------
  // opcode classes
  // -------------------------------------------------
  function automatic logic is_arr(input logic [7:0] op);
    return op inside {OP_PP, OP_PP4, OP_PPQ_A, OP_PPQ_B, OP_PPQ4_A, OP_PPQ4_B,
                      OP_SE_A, OP_SE_B, OP_SE4, OP_BE32, OP_BE32_4, OP_BE64,
                      OP_BE64_4, OP_CE_A, OP_CE_B};
  endfunction

  function automatic logic is_addr4(input logic [7:0] op);
    return op inside {OP_PP4, OP_PPQ4_A, OP_PPQ4_B, OP_SE4, OP_BE32_4, OP_BE64_4};
  endfunction

  function automatic logic has_addr(input logic [7:0] op);
    return is_arr(op) && !(op inside {OP_CE_A, OP_CE_B});
  endfunction

  function automatic logic busy_ok(input logic [7:0] op);
    return op inside {OP_READ_STATUS_INSTR, OP_RDFR, OP_RDERP, OP_RST_EN, OP_RST, OP_SUSP_A, OP_SUSP_B};
  endfunction

  function automatic logic addr_protected(input logic [3:0] bp, input logic [31:0] a);
    logic [10:0] blk;
    logic [10:0] span;
    blk = {1'b0, a[ADDR_BLK_HI:ADDR_BLK_LO]};
    span = 11'h001 << (bp - 4'h1);
    if (bp == BP_NONE)
      return 1'b0;
    if (bp >= BP_ALL_FROM)
      return 1'b1;
    return blk >= (BLOCK_COUNT - span);
  endfunction

  // -------------------------------------------------
  // serial shifter
  // -------------------------------------------------
  fsw_spi_shift u_shift (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pins(spi_in),
    .tx_byte(status),
    .rx_byte(rx_byte),
    .rx_valid(rx_valid),
    .so_bit(so_bit),
    .frame_end(frame_end)
  );

  // only the volatile copy ever reaches the read path
  assign status = {vol_hi_r, wel_r, busy_r};

  // -------------------------------------------------
  // shared pin synchronisers
  // -------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      wp_meta_r <= 1'b1;
      wp_sync_r <= 1'b1;
      hold_meta_r <= 1'b1;
      hold_sync_r <= 1'b1;
    end
    else if (clk_en)
    begin
      wp_meta_r <= wp_n_dl2_in;
      wp_sync_r <= wp_meta_r;
      hold_meta_r <= hold_n_dl3_in;
      hold_sync_r <= hold_meta_r;
    end

  // pins serve as protect and reset only while quad is off
  assign wp_low = ~wp_sync_r & ~vol_hi_r[ST_QE - 2];
  assign locked = vol_hi_r[ST_LOCK - 2] & wp_low;

  // -------------------------------------------------
  // instruction framing
  // -------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      frame_r <= FR_OPC;
      opcode_r <= 8'h00;
      addr_r <= 32'h0000_0000;
      addr_left_r <= 3'h0;
      data_r <= 8'h00;
      data_seen_r <= 1'b0;
      read_mode_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (frame_end)
      begin
        frame_r <= FR_OPC;
        data_seen_r <= 1'b0;
        read_mode_r <= 1'b0;
      end
      else if (rx_valid)
      begin
        unique case (frame_r)
          FR_OPC:
          begin
            opcode_r <= rx_byte;
            addr_r <= 32'h0000_0000;
            if (busy_r && !busy_ok(rx_byte))
              frame_r <= FR_SKIP;
            else if (has_addr(rx_byte))
            begin
              frame_r <= FR_ADDR;
              addr_left_r <= is_addr4(rx_byte) ? 3'h4 : 3'h3;
            end
            else
            begin
              frame_r <= FR_DATA;
              read_mode_r <= (rx_byte == OP_READ_STATUS_INSTR);
            end
          end
          FR_ADDR:
          begin
            addr_r <= {addr_r[23:0], rx_byte};
            addr_left_r <= addr_left_r - 3'h1;
            if (addr_left_r == 3'h1)
              frame_r <= FR_DATA;
          end
          FR_DATA:
          begin
            if (!data_seen_r)
            begin
              data_r <= rx_byte;
              data_seen_r <= 1'b1;
            end
          end
          FR_SKIP:
          begin
            frame_r <= FR_SKIP;
          end
        endcase
      end
    end

  // -------------------------------------------------
  // decode at chip select release
  // -------------------------------------------------
  assign exec = frame_end & (frame_r == FR_DATA);
  assign is_ce = opcode_r inside {OP_CE_A, OP_CE_B};
  assign write_status_instr_ok = exec & (opcode_r == OP_WRITE_STATUS_INSTR) & data_seen_r & ~busy_r & ~locked;
  assign write_status_instr_vol = write_status_instr_ok & vol_arm_r;
  assign write_status_instr_nv = write_status_instr_ok & ~vol_arm_r & wel_r;
  assign arr_ok = exec & is_arr(opcode_r) & wel_r & ~busy_r
                  & (is_ce ? (vol_hi_r[ST_BP_HI-2:ST_BP_LO-2] == BP_NONE)
                     : !addr_protected(vol_hi_r[ST_BP_HI-2:ST_BP_LO-2], addr_r));
  assign aux_nv = opcode_r inside {OP_WRFR, OP_SRPNV, OP_VOLATILE_READ_PARAM_WRITE, OP_BRV};
  assign aux_ok = exec & ~busy_r
                  & ((aux_nv & wel_r)
                     | (opcode_r inside {OP_ALT_RP, OP_ALT_BR}));
  assign done_evt = busy_r & (busy_tmr_r ? (tmr_r == TMR_W'(0)) : op_done);

  // -------------------------------------------------
  // status bits
  // -------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      nv_hi_r <= NV_RESET;
      vol_hi_r <= 6'h00;
      pwr_up_done_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!pwr_up_done_r)
      begin
        vol_hi_r <= nv_hi_r;
        pwr_up_done_r <= 1'b1;
      end
      else if (exec && opcode_r == OP_RST && rst_arm_r)
        vol_hi_r <= nv_hi_r;
      else if (write_status_instr_vol)
        vol_hi_r <= data_r[ST_LOCK:ST_BP_LO];
      else if (write_status_instr_nv)
      begin
        nv_hi_r <= data_r[ST_LOCK:ST_BP_LO];
        vol_hi_r <= data_r[ST_LOCK:ST_BP_LO];
      end
    end

  // volatile write status never touches the latch; nv write status clears it on completion
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      wel_r <= 1'b0;
    else if (clk_en)
    begin
      if (exec && !busy_r && opcode_r == OP_WRITE_ENABLE_INSTR)
        wel_r <= 1'b1;
      else if (exec && !busy_r && opcode_r == OP_WRITE_DISABLE_INSTR)
        wel_r <= 1'b0;
      else if (done_evt || (aux_ok && aux_nv))
        wel_r <= 1'b0;
      else if (exec && opcode_r == OP_RST && rst_arm_r)
        wel_r <= 1'b0;
    end

  // arming by 50h lasts for the next instruction only
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      vol_arm_r <= 1'b0;
      rst_arm_r <= 1'b0;
    end
    else if (clk_en && exec)
    begin
      vol_arm_r <= (opcode_r == OP_VWREN) & ~busy_r;
      rst_arm_r <= (opcode_r == OP_RST_EN);
    end

  // -------------------------------------------------
  // busy tracking
  // -------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      busy_r <= 1'b0;
      busy_tmr_r <= 1'b0;
      tmr_r <= TMR_W'(0);
    end
    else if (clk_en)
    begin
      if (write_status_instr_nv)
      begin
        busy_r <= 1'b1;
        busy_tmr_r <= 1'b1;
        tmr_r <= TMR_W'(NV_WR_CYCLES - 1);
      end
      else if (arr_ok)
      begin
        busy_r <= 1'b1;
        busy_tmr_r <= 1'b0;
      end
      else if (done_evt)
        busy_r <= 1'b0;
      else if (busy_r && busy_tmr_r)
        tmr_r <= tmr_r - TMR_W'(1);
    end

  // -------------------------------------------------
  // requests to the rest of the device
  // -------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      op_start <= 1'b0;
      op_req <= '0;
      aux_write <= 1'b0;
      aux_req <= '0;
      suspend_req <= 1'b0;
      soft_reset_req <= 1'b0;
      hw_reset_req <= 1'b0;
    end
    else if (clk_en)
    begin
      op_start <= arr_ok;
      aux_write <= aux_ok;
      suspend_req <= exec & busy_r & (opcode_r inside {OP_SUSP_A, OP_SUSP_B});
      soft_reset_req <= exec & (opcode_r == OP_RST) & rst_arm_r;
      hw_reset_req <= ~hold_sync_r & ~vol_hi_r[ST_QE - 2];
      if (arr_ok)
        op_req <= '{opcode: opcode_r, addr: addr_r, data: data_r};
      if (aux_ok)
        aux_req <= '{opcode: opcode_r, addr: addr_r, data: data_r};
    end

  // -------------------------------------------------
  // pin outputs
  // -------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      so_out <= 1'b0;
      so_oe <= 1'b0;
      wp_n_dl2_out <= 1'b0;
      wp_n_dl2_oe <= 1'b0;
      hold_n_dl3_out <= 1'b0;
      hold_n_dl3_oe <= 1'b0;
      pins_are_data <= 1'b0;
      status_out <= 8'h00;
    end
    else if (clk_en)
    begin
      so_out <= so_bit;
      so_oe <= read_mode_r;
      wp_n_dl2_out <= 1'b0;
      wp_n_dl2_oe <= 1'b0;
      hold_n_dl3_out <= 1'b0;
      hold_n_dl3_oe <= 1'b0;
      pins_are_data <= vol_hi_r[ST_QE - 2];
      status_out <= status;
    end

endmodule
`default_nettype wire

// >>> verif/fsw_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fsw_ctrl_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // watched ports
  input wire logic hold_n_dl3_in,
  input wire logic wp_n_dl2_oe,
  input wire logic hold_n_dl3_oe,
  input wire logic pins_are_data,
  input wire logic op_start,
  input wire fsw_pkg::fsw_op_t op_req,
  input wire logic op_done,
  input wire logic aux_write,
  input wire logic suspend_req,
  input wire logic hw_reset_req,
  input wire logic [7:0] status_out
);
  import fsw_pkg::*;
  // ---------------------------------
  // properties
  // ---------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  sequence hold_low_s;
    (!pins_are_data && !hold_n_dl3_in) [*4];
  endsequence
  sequence hold_idle_s;
    (hold_n_dl3_in || pins_are_data) [*4];
  endsequence
  sequence busy_up_s;
    ##[0:2] status_out[ST_BUSY];
  endsequence
  busy_on_start_a: assert property (op_start |-> busy_up_s)
    else $error("busy flag did not rise after an accepted operation");
  start_latch_a: assert property (op_start |-> status_out[ST_WEL])
    else $error("operation started without write enable latch");
  done_clears_a: assert property (op_done |-> ##[1:3] (status_out[1:0] == 2'b00))
    else $error("completion left busy or latch set");
  chip_erase_bp_a: assert property (op_start && (op_req.opcode == OP_CE_A || op_req.opcode == OP_CE_B)
    |-> status_out[ST_BP_HI:ST_BP_LO] == BP_NONE)
    else $error("chip erase started with protect bits set");
  busy_ignore_a: assert property ($past(status_out[ST_BUSY]) |-> !op_start && !aux_write)
    else $error("instruction accepted while busy");
  suspend_busy_a: assert property (suspend_req |-> $past(status_out[ST_BUSY]))
    else $error("suspend request while ready");
  shared_oe_a: assert property (!wp_n_dl2_oe && !hold_n_dl3_oe)
    else $error("shared pin driven");
  pins_role_a: assert property ($stable(status_out[ST_QE]) |-> pins_are_data == status_out[ST_QE])
    else $error("shared pin role differs from quad bit");
  hold_reset_a: assert property (hold_low_s |-> hw_reset_req)
    else $error("hold low did not request reset");
  hold_idle_a: assert property (hold_idle_s |-> !hw_reset_req)
    else $error("reset requested without hold low");
endmodule
bind fsw_ctrl fsw_ctrl_sva fsw_ctrl_sva_inst (.sys_clk, .rst_n, .hold_n_dl3_in, .wp_n_dl2_oe, .hold_n_dl3_oe,
  .pins_are_data, .op_start, .op_req, .op_done, .aux_write, .suspend_req, .hw_reset_req, .status_out);
`default_nettype wire

// >>> verif/fsw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fsw_host_model (
  // serial pins toward the device
  output var fsw_pkg::fsw_spi_in_t spi,
  input wire logic so
);
  // ---------------------------------
  // frame driver, mode 0, 160 ns clock
  // ---------------------------------
  initial spi = '{sck: 1'b0, cs_n: 1'b1, si: 1'b0};
  task automatic frame(input logic [7:0] tx [$], input int n_rd, output logic [7:0] rd [$]);
    logic [7:0] b;
    rd = {};
    spi.cs_n = 1'b0;
    for (int i = 0; i < tx.size() + n_rd; i++)
    begin
      b = (i < tx.size()) ? tx[i] : 8'h00;
      for (int k = 7; k >= 0; k--)
      begin
        spi.si = b[k];
        #80 spi.sck = 1'b1;
        #79 b[k] = so;
        #1 spi.sck = 1'b0;
      end
      if (i >= tx.size()) rd.push_back(b);
    end
    #80 spi.cs_n = 1'b1;
    #200;
  endtask
  // idle data line carries no stale value
  always #160 if (spi.cs_n) spi.si = ~spi.si;
endmodule
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fsw_pkg::*;
  localparam logic [7:0] PE_OPS [15] = '{OP_PP, OP_PP4, OP_PPQ_A, OP_PPQ_B, OP_PPQ4_A, OP_PPQ4_B, OP_SE_A,
    OP_SE_B, OP_SE4, OP_BE32, OP_BE32_4, OP_BE64, OP_BE64_4, OP_CE_A, OP_CE_B};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n_dl2_in = 1'b1;
  logic hold_n_dl3_in = 1'b1;
  logic op_done = 1'b0;
  logic clk_en = 1'b1;
  fsw_spi_in_t spi_in;
  logic so_out, so_oe, wp_n_dl2_out, wp_n_dl2_oe, hold_n_dl3_out, hold_n_dl3_oe, pins_are_data;
  logic op_start, aux_write, suspend_req, soft_reset_req, hw_reset_req;
  fsw_op_t op_req, aux_req;
  logic [7:0] status_out;
  logic [7:0] rd [$];
  int err_total = 0;
  int checks_done = 0;
  int n_op = 0, n_aux = 0, n_susp = 0, n_srst = 0, n_oe = 0;
  always #10 sys_clk = ~sys_clk;
  fsw_ctrl fsw_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .spi_in(spi_in), .so_out(so_out),
    .so_oe(so_oe), .wp_n_dl2_in(wp_n_dl2_in), .wp_n_dl2_out(wp_n_dl2_out), .wp_n_dl2_oe(wp_n_dl2_oe),
    .hold_n_dl3_in(hold_n_dl3_in), .hold_n_dl3_out(hold_n_dl3_out), .hold_n_dl3_oe(hold_n_dl3_oe),
    .pins_are_data(pins_are_data), .op_start(op_start), .op_req(op_req), .op_done(op_done),
    .aux_write(aux_write), .aux_req(aux_req), .suspend_req(suspend_req), .soft_reset_req(soft_reset_req),
    .hw_reset_req(hw_reset_req), .status_out(status_out));
  fsw_host_model fsw_host_model_inst (.spi(spi_in), .so(so_out));
  always @(posedge sys_clk)
  begin
    if (op_start === 1'b1) n_op <= n_op + 1;
    if (aux_write === 1'b1) n_aux <= n_aux + 1;
    if (suspend_req === 1'b1) n_susp <= n_susp + 1;
    if (soft_reset_req === 1'b1) n_srst <= n_srst + 1;
    if (so_oe === 1'b1) n_oe <= n_oe + 1;
  end
  // ---------------------------------
  // access tasks
  // ---------------------------------
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] tx [$]);
    logic [7:0] q [$];
    @(negedge sys_clk) #3;
    fsw_host_model_inst.frame(tx, 0, q);
  endtask
  task automatic read_status_instr(input int n, input logic [7:0] exp);
    @(negedge sys_clk) #3;
    fsw_host_model_inst.frame({OP_READ_STATUS_INSTR}, n, rd);
    foreach (rd[i]) chk(rd[i], exp);
  endtask
  task automatic pulse_done;
    @(negedge sys_clk) op_done = 1'b1;
    @(negedge sys_clk) op_done = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic wait_ready;
    int n = 0;
    do
    begin
      @(negedge sys_clk) #3;
      fsw_host_model_inst.frame({OP_READ_STATUS_INSTR}, 1, rd);
      n++;
    end while (rd[0][ST_BUSY] !== 1'b0 && n < 40);
    chk(rd[0][ST_BUSY], 1'b0);
  endtask
  task automatic stop_test;
    if (err_total == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ---------------------------------
  // tests
  // ---------------------------------
  initial
  begin
    #40 rst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(status_out, 8'h00);
    read_status_instr(1, 8'h00);
    chk({so_oe, n_oe != 0}, 2'b01);
    foreach (PE_OPS[i]) send({PE_OPS[i], 8'h00, 8'h01, 8'h00, 8'h00});
    chk(n_op, 0);
    foreach (PE_OPS[i])
    begin
      send({OP_WRITE_ENABLE_INSTR});
      read_status_instr(3, 8'h02);
      send({PE_OPS[i], 8'h00, 8'h01, 8'h00, 8'h00});
      chk({n_op[7:0], op_req.opcode, status_out[1:0]}, {8'(i + 1), PE_OPS[i], 2'b11});
      pulse_done();
      chk(status_out, 8'h00);
    end
    send({OP_WRITE_ENABLE_INSTR});
    send({OP_SE_B, 8'h00, 8'h10, 8'h00});
    send({OP_WRITE_DISABLE_INSTR});
    send({OP_SUSP_A});
    read_status_instr(1, 8'h03);
    chk(n_susp, 1);
    pulse_done();
    send({OP_WRITE_ENABLE_INSTR});
    send({OP_WRITE_STATUS_INSTR, 8'h28});
    read_status_instr(0, 8'h00);
    fsw_host_model_inst.frame({OP_READ_STATUS_INSTR}, 1, rd);
    chk(rd[0][ST_BUSY], 1'b1);
    wait_ready();
    read_status_instr(1, 8'h28);
    send({OP_WRITE_ENABLE_INSTR});
    send({OP_SE4, 8'h02, 8'h00, 8'h00, 8'h00});
    send({OP_CE_A});
    read_status_instr(1, 8'h2A);
    send({OP_SE4, 8'h01, 8'hFF, 8'h00, 8'h00});
    chk({n_op[7:0], op_req.addr}, {8'd17, 32'h01FF_0000});
    pulse_done();
    send({OP_VOLATILE_READ_PARAM_WRITE, 8'h11});
    send({OP_ALT_RP, 8'h11});
    send({OP_ALT_BR, 8'h22});
    chk({n_aux[7:0], aux_req.opcode, aux_req.data}, {8'd2, OP_ALT_BR, 8'h22});
    send({OP_WRITE_STATUS_INSTR, 8'h80});
    read_status_instr(1, 8'h28);
    send({OP_VWREN});
    chk(status_out[ST_WEL], 1'b0);
    send({OP_WRITE_STATUS_INSTR, 8'h80});
    read_status_instr(1, 8'h80);
    @(negedge sys_clk) wp_n_dl2_in = 1'b0;
    send({OP_VWREN});
    send({OP_WRITE_STATUS_INSTR, 8'h00});
    read_status_instr(1, 8'h80);
    @(negedge sys_clk) wp_n_dl2_in = 1'b1;
    send({OP_VWREN});
    send({OP_WRITE_STATUS_INSTR, 8'h40});
    read_status_instr(1, 8'h40);
    @(negedge sys_clk) hold_n_dl3_in = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk({pins_are_data, hw_reset_req}, 2'b10);
    hold_n_dl3_in = 1'b1;
    send({OP_VWREN});
    send({OP_WRITE_STATUS_INSTR, 8'h00});
    @(negedge sys_clk) hold_n_dl3_in = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk({pins_are_data, hw_reset_req}, 2'b01);
    hold_n_dl3_in = 1'b1;
    repeat (10) @(negedge sys_clk);
    send({OP_RST_EN});
    send({OP_RST});
    chk({n_srst[7:0], wp_n_dl2_out, hold_n_dl3_out}, {8'd1, 2'b00});
    read_status_instr(1, 8'h28);
    send({OP_WRITE_ENABLE_INSTR});
    @(negedge sys_clk) clk_en = 1'b0;
    send({OP_WRITE_DISABLE_INSTR});
    @(negedge sys_clk) clk_en = 1'b1;
    read_status_instr(1, 8'h2A);
    stop_test();
  end
  initial
  begin
    #1_000_000;
    err_total++;
    stop_test();
  end
endmodule
`default_nettype wire
